// *** rtl/homing_params.svh ***
// method range and speed encoding constants for the homing sequencer
`ifndef HOMING_PARAMS_SVH
`define HOMING_PARAMS_SVH
`define METHOD_MAX 4'h9
`define SPEED_STOP 2'h0
`define SPEED_LOW 2'h1
`define SPEED_HIGH 2'h2
`endif

// *** rtl/homing_pkg.sv ***
// types for the homing sequencer
package homing_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEEK = 3'h1,
    ST_BACK = 3'h3,
    ST_INDEX = 3'h2,
    ST_DONE = 3'h6,
    ST_FAIL = 3'h7
  } state_type;
endpackage : homing_pkg

// *** rtl/homing_sequence_controller.sv ***
// homing search sequencer for one servo axis
//
// Behaviour
// (RULE1) methods 0 to 9 select direction and sources
// (RULE2) method 0: home switch decelerates and homes
// (RULE3) method 0: forward, home at switch rise
// (RULE4) method 0: forward limit reverses, stop at edge
// (RULE5) method 0: switch high, reverse low to fall
// (RULE6) method 2: switch rise, then forward index
// (RULE7) method 2: limit reverses to fall, forward index
// (RULE8) method 2: switch high, reverse, forward index
// (RULE9) method 4: home at forward limit rise
// (RULE10) method 4: limit active, home at its fall
// (RULE11) method 6: limit rise, first reverse index
// (RULE12) method 6: limit active, fall, reverse index
// (RULE13) method 8: stop at first forward index
// (RULE14) high forward limit blocks forward motion
// (RULE15) odd methods mirror the preceding even one
`timescale 1ns/10ps
`include "homing_params.svh"
`default_nettype none
module homing_sequence_controller
  import homing_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // command
  input wire logic start,
  input wire logic [3:0] method,
  // field inputs, asynchronous
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  input wire logic home_switch_input,
  input wire logic index_pulse,
  // motion command and status
  output logic run_reverse,
  output logic [1:0] speed_sel,
  output logic busy,
  output logic home_found,
  output logic home_failed
);
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] prev_reg;
  logic [3:0] meth_reg;
  logic [3:0] meth_next;
  state_type state_reg;
  state_type state_next;
  logic rev_reg;
  logic rev_next;
  logic [1:0] spd_reg;
  logic [1:0] spd_next;
  logic found_reg;
  logic found_next;
  logic fail_reg;
  logic fail_next;
  logic own_lim;
  logic far_lim;
  logic home_sw;
  logic idx;
  logic home_rise;
  logic home_fall;
  logic lim_rise;
  logic lim_fall;
  logic idx_rise;
  logic mirror;
  logic [1:0] group;
  logic index_home;

  // two-stage synchronisers, then edge history
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg <= 4'h0;
    end else begin
      sync1_reg <= {index_pulse, home_switch_input, reverse_limit_input, forward_limit_input};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // limit level on one side of travel
  function automatic logic pick_side(input logic rev, input logic [1:0] lims);
    return rev ? lims[1] : lims[0];
  endfunction : pick_side

  // mirroring picks limit side for odd methods
  // (RULE15) swap limits when mirrored
  assign mirror = meth_reg[0];
  assign group = meth_reg[3:1] == 3'h0 ? 2'h0 : meth_reg[3:1] == 3'h1 ? 2'h1 :
                 meth_reg[3:1] == 3'h2 ? 2'h2 : meth_reg[3:1] == 3'h3 ? 2'h3 : 2'h0;
  // methods 8 and 9 home on the index alone
  assign index_home = meth_reg[3:1] == 3'h4;
  assign own_lim = pick_side(mirror, sync2_reg[1:0]);
  assign far_lim = pick_side(~mirror, sync2_reg[1:0]);
  assign home_sw = sync2_reg[2];
  assign idx = sync2_reg[3];
  assign home_rise = home_sw & ~prev_reg[2];
  assign home_fall = ~home_sw & prev_reg[2];
  assign lim_rise = own_lim & ~pick_side(mirror, prev_reg[1:0]);
  assign lim_fall = ~own_lim & pick_side(mirror, prev_reg[1:0]);
  assign idx_rise = idx & ~prev_reg[3];

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    meth_next = meth_reg;
    rev_next = rev_reg;
    spd_next = spd_reg;
    found_next = found_reg;
    fail_next = fail_reg;
    case (state_reg)
      ST_IDLE, ST_DONE, ST_FAIL: begin
        if (start) begin
          // (RULE1) accept methods 0 to 9
          if (method > `METHOD_MAX) begin
            state_next = ST_FAIL;
            fail_next = 1'b1;
            found_next = 1'b0;
          end else begin
            meth_next = method;
            found_next = 1'b0;
            fail_next = 1'b0;
            rev_next = method[0];
            spd_next = `SPEED_HIGH;
            state_next = ST_SEEK;
            // (RULE14) own limit high: no start into it
            if (method[3:2] == 2'h0 && pick_side(method[0], sync2_reg[1:0])) begin
              rev_next = ~method[0];
              state_next = ST_BACK;
            end
            // (RULE5) switch high: reverse slowly
            if (method[3:2] == 2'h0 && home_sw) begin
              rev_next = ~method[0];
              spd_next = `SPEED_LOW;
              state_next = ST_BACK;
            end
            // (RULE10) limit active: reverse at once
            if ((method[3:1] == 3'h2 || method[3:1] == 3'h3)
                && pick_side(method[0], sync2_reg[1:0])) begin
              rev_next = ~method[0];
              spd_next = `SPEED_LOW;
              state_next = ST_BACK;
            end
            // (RULE13) index methods refuse a blocked start
            if (method[3:1] == 3'h4 && pick_side(method[0], sync2_reg[1:0])) begin
              spd_next = `SPEED_STOP;
              fail_next = 1'b1;
              state_next = ST_FAIL;
            end
          end
        end
      end
      ST_SEEK: begin
        if (!index_home && (group == 2'h0 || group == 2'h1)) begin
          // (RULE2) home switch rise decelerates
          if (home_rise) begin
            spd_next = `SPEED_LOW;
            // (RULE3) home at deceleration point
            state_next = group == 2'h0 ? ST_DONE : ST_INDEX;
            // (RULE6) then forward index search
            found_next = group == 2'h0;
            if (group == 2'h0) begin
              spd_next = `SPEED_STOP;
            end
          end else if (own_lim) begin
            // (RULE4) limit met: reverse at high speed
            // (RULE14) high level blocks this direction
            rev_next = ~mirror;
            spd_next = `SPEED_HIGH;
            state_next = ST_BACK;
          end
        end else if (group == 2'h2 || group == 2'h3) begin
          // (RULE9) limit rise is the slow-down point
          if (lim_rise) begin
            if (group == 2'h2) begin
              spd_next = `SPEED_STOP;
              found_next = 1'b1;
              state_next = ST_DONE;
            end else begin
              // (RULE11) search index in reverse
              rev_next = ~mirror;
              spd_next = `SPEED_LOW;
              state_next = ST_INDEX;
            end
          end else if (far_lim) begin
            spd_next = `SPEED_STOP;
            fail_next = 1'b1;
            state_next = ST_FAIL;
          end
        end else begin
          // (RULE13) first index: stop and home
          if (idx_rise) begin
            spd_next = `SPEED_STOP;
            found_next = 1'b1;
            state_next = ST_DONE;
          end else if (own_lim) begin
            spd_next = `SPEED_STOP;
            fail_next = 1'b1;
            state_next = ST_FAIL;
          end
        end
      end
      ST_BACK: begin
        if (group == 2'h2 || group == 2'h3) begin
          // (RULE12) limit fall then reverse index
          if (lim_fall) begin
            spd_next = group == 2'h2 ? `SPEED_STOP : `SPEED_LOW;
            found_next = group == 2'h2;
            state_next = group == 2'h2 ? ST_DONE : ST_INDEX;
          end
        end else if (spd_reg == `SPEED_HIGH && home_rise && group == 2'h0) begin
          // (RULE4) stop immediately on the edge
          spd_next = `SPEED_STOP;
          found_next = 1'b1;
          state_next = ST_DONE;
        end else if (home_fall) begin
          // (RULE7) reverse to fall, then forward index
          // (RULE8) same from switch high at start
          rev_next = mirror;
          spd_next = group == 2'h0 ? `SPEED_STOP : `SPEED_LOW;
          found_next = group == 2'h0;
          state_next = group == 2'h0 ? ST_DONE : ST_INDEX;
        end else if (far_lim) begin
          spd_next = `SPEED_STOP;
          fail_next = 1'b1;
          state_next = ST_FAIL;
        end
      end
      ST_INDEX: begin
        if (idx_rise) begin
          spd_next = `SPEED_STOP;
          found_next = 1'b1;
          state_next = ST_DONE;
        end else if (pick_side(rev_reg, sync2_reg[1:0])) begin
          spd_next = `SPEED_STOP;
          fail_next = 1'b1;
          state_next = ST_FAIL;
        end
      end
      default: begin
        state_next = ST_IDLE;
        spd_next = `SPEED_STOP;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      meth_reg <= 4'h0;
      rev_reg <= 1'b0;
      spd_reg <= `SPEED_STOP;
      found_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      meth_reg <= meth_next;
      rev_reg <= rev_next;
      spd_reg <= spd_next;
      found_reg <= found_next;
      fail_reg <= fail_next;
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_reverse <= 1'b0;
      speed_sel <= 2'h0;
      busy <= 1'b0;
      home_found <= 1'b0;
      home_failed <= 1'b0;
    end else begin
      run_reverse <= rev_next;
      speed_sel <= spd_next;
      busy <= state_next == ST_SEEK || state_next == ST_BACK || state_next == ST_INDEX;
      home_found <= found_next;
      home_failed <= fail_next;
    end
  end
endmodule : homing_sequence_controller
`default_nettype wire

// *** verification/axis_model.sv ***
// behavioural axis with switches and index marks
`timescale 1ns/10ps
`default_nettype none
module axis_model (
  // clock and preset
  input wire logic clk_sys,
  input wire logic load,
  input wire logic signed [31:0] set_pos,
  // motion command
  input wire logic run_reverse,
  input wire logic [1:0] speed_sel,
  // field signals and position
  output logic forward_limit_input,
  output logic reverse_limit_input,
  output logic home_switch_input,
  output logic index_pulse,
  output logic signed [31:0] pos
);
  logic signed [31:0] step;
  // high speed 4, low 1 per cycle
  assign step = (speed_sel == 2'h2) ? 4 : (speed_sel == 2'h1) ? 1 : 0;
  // position moves each clock
  initial pos = 100;
  always @(posedge clk_sys) begin
    if (load) pos <= set_pos;
    else pos <= run_reverse ? pos - step : pos + step;
  end
  assign forward_limit_input = pos >= 1000;
  assign reverse_limit_input = pos <= 0;
  // switch zone and index marks
  assign home_switch_input = pos >= 400 && pos < 600;
  assign index_pulse = (pos % 100) >= 50 && (pos % 100) <= 53;
endmodule : axis_model
`default_nettype wire

// *** verification/homing_checker_props.sv ***
// port assertions for the homing sequencer
`timescale 1ns/10ps
`default_nettype none
module homing_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // command
  input wire logic start,
  input wire logic [3:0] method,
  // field inputs
  input wire logic forward_limit_input,
  input wire logic reverse_limit_input,
  input wire logic home_switch_input,
  input wire logic index_pulse,
  // motion command and status
  input wire logic run_reverse,
  input wire logic [1:0] speed_sel,
  input wire logic busy,
  input wire logic home_found,
  input wire logic home_failed
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // accepted start and settled levels
  sequence s_accept; start && !busy; endsequence
  sequence s_home_on; home_switch_input [*4]; endsequence
  sequence s_flim_on; forward_limit_input [*4]; endsequence
  sequence s_flim_off; (!forward_limit_input) [*3]; endsequence
  sequence s_rlim_off; (!reverse_limit_input) [*3]; endsequence
  a_bad_method: assert property (s_accept ##0 method > 4'h9 |=> home_failed && !busy)
    else $error("bad method not refused");
  a_fwd_launch: assert property (s_flim_off ##0 s_accept ##0 method == 4'h8
    |=> busy && speed_sel == 2'h2 && !run_reverse) else $error("no forward launch");
  a_mirror_launch: assert property (s_rlim_off ##0 s_accept ##0 method == 4'h9
    |=> busy && speed_sel == 2'h2 && run_reverse) else $error("no reverse launch");
  a_on_switch: assert property (s_home_on ##0 s_accept ##0 method == 4'h0
    |=> run_reverse && speed_sel == 2'h1) else $error("no slow reverse off switch");
  a_on_limit: assert property (s_flim_on ##0 s_accept ##0 method == 4'h4
    |=> run_reverse && busy) else $error("no reverse off limit");
  a_fwd_blocked: assert property (forward_limit_input [*5]
    |-> !(busy && speed_sel != 2'h0 && !run_reverse)) else $error("forward run at limit");
  a_found_still: assert property (home_found |-> !busy && speed_sel == 2'h0 && !home_failed)
    else $error("moving after home");
  a_found_hold: assert property (home_found && !start |=> home_found)
    else $error("home flag dropped");
endmodule : homing_checker
bind homing_sequence_controller homing_checker chk (.clk_sys(clk_sys), .rstn(rstn),
  .start(start), .method(method), .forward_limit_input(forward_limit_input),
  .reverse_limit_input(reverse_limit_input), .home_switch_input(home_switch_input),
  .index_pulse(index_pulse), .run_reverse(run_reverse), .speed_sel(speed_sel),
  .busy(busy), .home_found(home_found), .home_failed(home_failed));
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the homing sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef struct {logic [3:0] m; int p; logic ok; int h;} case_type;
  logic clk_sys = 1'b0, rstn = 1'b0, start = 1'b0, load = 1'b0;
  logic [3:0] method = 4'h0;
  logic signed [31:0] set_pos = 32'h64;
  logic fwd_lim, rev_lim, home_sw, index, run_reverse, busy, home_found, home_failed;
  logic [1:0] speed_sel;
  logic signed [31:0] pos;
  int failures = 0, num_checks = 0, cyc = 0;
  case_type rows [18] = '{
    '{4'h0, 100, 1'b1, 400},
    '{4'h0, 700, 1'b1, 600},
    '{4'h0, 500, 1'b1, 400},
    '{4'h1, 900, 1'b1, 600},
    '{4'h0, 1010, 1'b1, 600},
    '{4'h2, 100, 1'b1, 450},
    '{4'h2, 700, 1'b1, 450},
    '{4'h2, 500, 1'b1, 450},
    '{4'h3, 900, 1'b1, 550},
    '{4'h4, 100, 1'b1, 1000},
    '{4'h4, 1010, 1'b1, 1000},
    '{4'h5, 900, 1'b1, 0},
    '{4'h6, 100, 1'b1, 950},
    '{4'h6, 1010, 1'b1, 950},
    '{4'h7, 300, 1'b1, 50},
    '{4'h8, 100, 1'b1, 150},
    '{4'h9, 100, 1'b1, 50},
    '{4'hA, 100, 1'b0, 0}};
  // design and far-side model
  homing_sequence_controller dut (.clk_sys(clk_sys), .rstn(rstn), .start(start),
    .method(method), .forward_limit_input(fwd_lim), .reverse_limit_input(rev_lim),
    .home_switch_input(home_sw), .index_pulse(index), .run_reverse(run_reverse),
    .speed_sel(speed_sel), .busy(busy), .home_found(home_found), .home_failed(home_failed));
  axis_model field (.clk_sys(clk_sys), .load(load), .set_pos(set_pos),
    .run_reverse(run_reverse), .speed_sel(speed_sel), .forward_limit_input(fwd_lim),
    .reverse_limit_input(rev_lim), .home_switch_input(home_sw), .index_pulse(index),
    .pos(pos));
  // clock and hang guard
  initial forever #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      results;
    end
  end
  task check(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask : check
  // one homing run from a preset position, optional start while busy
  task run(input logic [3:0] m, input int p, input logic ok, input int h, input bit poke);
    int n;
    @(posedge clk_sys);
    load <= 1'b1;
    set_pos <= p;
    @(posedge clk_sys);
    load <= 1'b0;
    repeat (5) @(posedge clk_sys);
    start <= 1'b1;
    method <= m;
    @(posedge clk_sys);
    start <= 1'b0;
    if (poke) begin
      repeat (10) @(posedge clk_sys);
      start <= 1'b1;
      method <= 4'hA;
      @(posedge clk_sys);
      start <= 1'b0;
    end
    #1;
    for (n = 0; n < 4000 && busy !== 1'b0; n++) @(posedge clk_sys);
    #1;
    check(home_found, ok);
    check(home_failed, !ok);
    if (ok) check(pos - h <= 30 && h - pos <= 30, 1'b1);
  endtask : run
  task results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // table, then start while busy and reset in mid-run
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    foreach (rows[i]) run(rows[i].m, rows[i].p, rows[i].ok, rows[i].h, 1'b0);
    run(4'h0, 100, 1'b1, 400, 1'b1);
    @(posedge clk_sys);
    start <= 1'b1;
    method <= 4'h0;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    check(busy, 1'b1);
    check(run_reverse, 1'b1);
    check(speed_sel == 2'h1, 1'b1);
    @(posedge clk_sys);
    rstn <= 1'b0;
    @(posedge clk_sys);
    #1;
    check(busy, 1'b0);
    check(speed_sel == 2'h0, 1'b1);
    check(run_reverse, 1'b0);
    check(home_found, 1'b0);
    @(posedge clk_sys);
    rstn <= 1'b1;
    run(4'h8, 100, 1'b1, 150, 1'b0);
    results;
  end
endmodule : tb
`default_nettype wire
